// [rtl/lrs_pkg.sv]
// package: constants and types of the log range and relative dB sequencer
package lrs_pkg;

    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] LRS_CTRL_OFS  = 8'h00;
    localparam logic [7:0] LRS_STAT_OFS  = 8'h04;
    localparam logic [7:0] LRS_DISP_OFS  = 8'h08;
    localparam logic [7:0] LRS_REF_OFS   = 8'h0c;

    // ==========================================================
    // control register fields
    localparam int LRS_CTRL_AUTO_BIT = 0;
    localparam int LRS_CTRL_MODE_LSB = 1;
    localparam int LRS_CTRL_BTN_BIT  = 3;
    localparam int LRS_CTRL_RUN_BIT  = 4;

    // status register fields
    localparam int LRS_STAT_RANGE_LSB = 0;
    localparam int LRS_STAT_UR_LAMP   = 3;
    localparam int LRS_STAT_OR_LAMP   = 4;
    localparam int LRS_STAT_BLANK     = 5;
    localparam int LRS_STAT_UR        = 6;
    localparam int LRS_STAT_OR        = 7;
    localparam int LRS_STAT_BUSY      = 8;
    localparam int LRS_STAT_MODE_LSB  = 9;

    // sign bit position in display and reference words
    localparam int LRS_SIGN_BIT = 16;

    // ==========================================================
    // ranges and reset values
    localparam logic [2:0] LRS_RANGE_MIN = 3'h1;
    localparam logic [2:0] LRS_RANGE_MAX = 3'h5;
    localparam logic [2:0] LRS_RANGE_RST = 3'h1;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        MODE_DBM,
        MODE_REF,
        MODE_REL,
        MODE_WATT
    } lrs_mode_t;

    typedef enum logic [1:0] {
        CLS_UNDER,
        CLS_IN,
        CLS_OVER,
        CLS_RSVD
    } lrs_class_t;

    typedef enum logic [3:0] {
        S_IDLE,
        S_MEAS,
        S_CLR_RANGE,
        S_SET_UR,
        S_SET_OR,
        S_RANGE_DN,
        S_RANGE_UP,
        S_CLR_CNT,
        S_LOAD_REF,
        S_REL_START,
        S_REL_FIRST,
        S_REL_RUN,
        S_XFER
    } lrs_state_t;

endpackage

// [rtl/lrs_seq.sv]
// module: log conversion result handling, auto-ranging and relative dB sequencer
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module lrs_seq
    import lrs_pkg::*;
#(
    parameter int CW = 14
) (
    input  wire logic          core_clk_i,
    input  wire logic          rst_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [7:0]    paddr_i,
    input  wire logic [31:0]   pwdata_i,
    output logic      [31:0]   prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    input  wire logic [CW-1:0] preset_count_i,
    input  wire logic          preset_sign_i,
    input  wire logic          conv_done_i,
    input  wire logic [1:0]    conv_class_i,
    output logic               ramp_enable_cmd_o,
    output logic               log_ramp_enable_o,
    output logic               count_cmd_o,
    output logic               clear_range_cmd_o,
    output logic               set_under_range_cmd_o,
    output logic               set_over_range_cmd_o,
    output logic               range_down_cmd_o,
    output logic               range_up_cmd_o,
    output logic               clear_count_cmd_o,
    output logic               load_reference_cmd_o,
    output logic               relative_step_cmd_o,
    output logic               display_transfer_cmd_o,
    output logic               relative_zero_flag_o,
    output logic               under_range_lamp_o,
    output logic               over_range_lamp_o,
    output logic               under_range_status_o,
    output logic               over_range_status_o,
    output logic               display_blank_o,
    output logic      [1:0]    status_code_o,
    output logic      [2:0]    range_o,
    output logic      [CW-1:0] display_count_o,
    output logic               display_sign_o
);

    // ==========================================================
    // elaboration check
    if (CW < 14 || CW > 16) begin : g_chk
        $error("lrs_seq: CW must be 14 to 16");
    end

    // ==========================================================
    // state
    typedef struct packed {
        lrs_state_t  st;
        lrs_mode_t   mode;
        lrs_mode_t   sel;
        logic        sel_pend;
        logic        auto_rng;
        logic        button;
        logic        run;
        lrs_class_t  cls;
        logic [2:0]  range;
        logic        ur_lamp;
        logic        or_lamp;
        logic        blank;
        logic        under_range_status;
        logic        over_range_status;
        logic [1:0]  status;
        logic [CW-1:0] main;
        logic        sign;
        logic [CW-1:0] ref_cnt;
        logic        ref_sign;
        logic [CW-1:0] rel_cnt;
        logic        rel_zero;
        logic [CW-1:0] disp;
        logic        disp_sign;
        logic        ramp;
        logic        log_ramp;
        logic        cnt;
        logic        c_clr_rng;
        logic        c_sur;
        logic        c_sor;
        logic        c_rdn;
        logic        c_rup;
        logic        c_clr_cnt;
        logic        c_lref;
        logic        c_rel;
        logic        c_xfer;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } lrs_reg_t;

    lrs_reg_t q;
    lrs_reg_t d;

    // one count of the main counter; stepping the magnitude down from
    // zero stands in for the borrow and flips the sign latch
    function automatic logic [CW:0] step_main(input logic [CW-1:0] c, input logic s,
                                              input logic up);
        logic [CW:0] r;
        r = {s, c};
        if (up) begin
            r = {s, c + {{(CW-1){1'b0}}, 1'b1}};
        end else if (c == '0) begin
            r = {~s, {{(CW-1){1'b0}}, 1'b1}};
        end else begin
            r = {s, c - {{(CW-1){1'b0}}, 1'b1}};
        end
        return r;
    endfunction

    logic apb_acc;
    assign apb_acc = psel_i && penable_i && !q.pready;

    always_comb begin
        d = q;
        {d.c_clr_rng, d.c_sur, d.c_sor, d.c_rdn, d.c_rup} = '0;
        {d.c_clr_cnt, d.c_lref, d.c_rel, d.c_xfer} = '0;
        d.log_ramp = q.ramp; // second phase follows the ramp command

        // ==========================================================
        // apb slave: one wait state, then answer
        d.pready  = apb_acc;
        d.pslverr = 1'b0;
        if (apb_acc) begin
            d.prdata = 32'h0000_0000;
            if (paddr_i == LRS_CTRL_OFS) begin
                d.prdata[LRS_CTRL_AUTO_BIT] = q.auto_rng;
                d.prdata[LRS_CTRL_MODE_LSB +: 2] = q.sel;
                d.prdata[LRS_CTRL_BTN_BIT] = q.button;
                d.prdata[LRS_CTRL_RUN_BIT] = q.run;
                if (pwrite_i) begin
                    d.auto_rng = pwdata_i[LRS_CTRL_AUTO_BIT];
                    d.sel      = lrs_mode_t'(pwdata_i[LRS_CTRL_MODE_LSB +: 2]);
                    d.sel_pend = 1'b1;
                    d.button   = pwdata_i[LRS_CTRL_BTN_BIT];
                    d.run      = pwdata_i[LRS_CTRL_RUN_BIT];
                end
            end else if (paddr_i == LRS_STAT_OFS) begin
                d.prdata[LRS_STAT_RANGE_LSB +: 3] = q.range;
                d.prdata[LRS_STAT_UR_LAMP] = q.ur_lamp;
                d.prdata[LRS_STAT_OR_LAMP] = q.or_lamp;
                d.prdata[LRS_STAT_BLANK]   = q.blank;
                d.prdata[LRS_STAT_UR]      = q.under_range_status;
                d.prdata[LRS_STAT_OR]      = q.over_range_status;
                d.prdata[LRS_STAT_BUSY]    = (q.st != S_IDLE);
                d.prdata[LRS_STAT_MODE_LSB +: 2] = q.mode;
                d.pslverr = pwrite_i;
            end else if (paddr_i == LRS_DISP_OFS) begin
                d.prdata[CW-1:0] = q.disp;
                d.prdata[LRS_SIGN_BIT] = q.disp_sign;
                d.pslverr = pwrite_i;
            end else if (paddr_i == LRS_REF_OFS) begin
                d.prdata[CW-1:0] = q.ref_cnt;
                d.prdata[LRS_SIGN_BIT] = q.ref_sign;
                d.pslverr = pwrite_i;
            end else begin
                d.pslverr = 1'b1;
            end
        end

        // ==========================================================
        // sequencer
        case (q.st)
            S_IDLE: begin
                // mode register loads only here, at the program cycle start
                if (q.button) begin
                    d.mode = MODE_REF;
                end else if (q.sel_pend) begin
                    d.mode = q.sel;
                end else if (q.mode == MODE_REF) begin
                    d.mode = MODE_REL;
                end
                // a pending selection consumed here; a write in this cycle wins
                if (!apb_acc || !pwrite_i || paddr_i != LRS_CTRL_OFS) begin
                    d.sel_pend = 1'b0;
                end
                if (q.run && d.mode != MODE_WATT) begin
                    d.main = preset_count_i;
                    d.sign = preset_sign_i;
                    d.st   = S_MEAS;
                end
            end
            S_MEAS: begin
                if (conv_done_i) begin
                    d.ramp = 1'b0;
                    d.cnt  = 1'b0;
                    d.cls  = lrs_class_t'(conv_class_i);
                    d.st   = S_CLR_RANGE;
                end else begin
                    d.ramp = 1'b1;
                    d.cnt  = 1'b1;
                    {d.sign, d.main} = step_main(q.main, q.sign, !q.sign);
                end
            end
            S_CLR_RANGE: begin
                d.c_clr_rng = 1'b1;
                {d.ur_lamp, d.or_lamp, d.blank, d.under_range_status, d.over_range_status} = '0;
                if (q.cls == CLS_UNDER) begin
                    d.st = S_SET_UR;
                end else if (q.cls == CLS_IN) begin
                    if (q.mode == MODE_DBM) begin
                        d.st = S_XFER;
                    end else if (q.mode == MODE_REF) begin
                        d.st = S_LOAD_REF;
                    end else begin
                        d.st = S_REL_START;
                    end
                end else begin
                    d.st = S_SET_OR;
                end
            end
            S_SET_UR: begin
                d.c_sur   = 1'b1;
                d.ur_lamp = 1'b1;
                d.under_range_status     = 1'b1;
                d.or_lamp = 1'b0;
                d.st      = S_SET_OR;
            end
            S_SET_OR: begin
                d.c_sor   = 1'b1;
                d.blank   = 1'b1;
                d.over_range_status     = 1'b1;
                d.or_lamp = !q.ur_lamp;
                if (q.cls == CLS_UNDER && q.auto_rng && q.range > LRS_RANGE_MIN) begin
                    d.st = S_RANGE_DN;
                end else if (q.cls != CLS_UNDER && q.auto_rng && q.range < LRS_RANGE_MAX) begin
                    d.st = S_RANGE_UP;
                end else if (q.mode == MODE_DBM) begin
                    d.st = S_XFER;
                end else begin
                    d.st = S_CLR_CNT;
                end
            end
            S_RANGE_DN: begin
                d.c_rdn = 1'b1;
                d.range = q.range - 3'h1;
                d.main  = preset_count_i;
                d.sign  = preset_sign_i;
                d.st    = S_MEAS;
            end
            S_RANGE_UP: begin
                d.c_rup = 1'b1;
                d.range = q.range + 3'h1;
                d.main  = preset_count_i;
                d.sign  = preset_sign_i;
                d.st    = S_MEAS;
            end
            S_CLR_CNT: begin
                d.c_clr_cnt = 1'b1;
                d.main = '0;
                d.sign = 1'b0;
                d.st   = (q.mode == MODE_REF) ? S_LOAD_REF : S_XFER;
            end
            S_LOAD_REF: begin
                d.c_lref   = 1'b1;
                d.ref_cnt  = q.main;
                d.ref_sign = q.sign;
                d.st       = (q.cls == CLS_IN) ? S_REL_START : S_XFER;
            end
            S_REL_START: begin
                d.c_clr_rng = 1'b1;
                {d.ur_lamp, d.or_lamp, d.blank, d.under_range_status, d.over_range_status} = '0;
                d.rel_cnt  = q.ref_cnt;
                d.rel_zero = 1'b1;
                d.st       = S_REL_FIRST;
            end
            S_REL_FIRST: begin
                d.c_rel   = 1'b1;
                d.rel_cnt = q.rel_cnt - {{(CW-1){1'b0}}, 1'b1};
                if (q.rel_cnt == '0) begin
                    d.rel_zero = 1'b0;
                end
                d.st = S_REL_RUN;
            end
            S_REL_RUN: begin
                if (!q.rel_zero) begin
                    d.st = S_XFER;
                end else begin
                    d.c_rel   = 1'b1;
                    d.cnt     = 1'b1;
                    d.rel_cnt = q.rel_cnt - {{(CW-1){1'b0}}, 1'b1};
                    if (q.rel_cnt == '0) begin
                        d.rel_zero = 1'b0;
                    end
                    {d.sign, d.main} = step_main(q.main, q.sign, q.sign != q.ref_sign);
                end
            end
            S_XFER: begin
                d.cnt       = 1'b0;
                d.c_xfer    = 1'b1;
                d.disp      = q.main;
                d.disp_sign = q.sign;
                d.st        = S_IDLE;
            end
            default: begin
                d.st = S_IDLE;
            end
        endcase
        d.status = {d.over_range_status, d.under_range_status};
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            q       <= '0;
            q.st    <= S_IDLE;
            q.mode  <= MODE_DBM;
            q.sel   <= MODE_DBM;
            q.cls   <= CLS_IN;
            q.range <= LRS_RANGE_RST;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // outputs
    assign prdata_o               = q.prdata;
    assign pready_o               = q.pready;
    assign pslverr_o              = q.pslverr;
    assign ramp_enable_cmd_o      = q.ramp;
    assign log_ramp_enable_o      = q.log_ramp;
    assign count_cmd_o            = q.cnt;
    assign clear_range_cmd_o      = q.c_clr_rng;
    assign set_under_range_cmd_o  = q.c_sur;
    assign set_over_range_cmd_o   = q.c_sor;
    assign range_down_cmd_o       = q.c_rdn;
    assign range_up_cmd_o         = q.c_rup;
    assign clear_count_cmd_o      = q.c_clr_cnt;
    assign load_reference_cmd_o   = q.c_lref;
    assign relative_step_cmd_o    = q.c_rel;
    assign display_transfer_cmd_o = q.c_xfer;
    assign relative_zero_flag_o   = q.rel_zero;
    assign under_range_lamp_o     = q.ur_lamp;
    assign over_range_lamp_o      = q.or_lamp;
    assign under_range_status_o   = q.under_range_status;
    assign over_range_status_o    = q.over_range_status;
    assign display_blank_o        = q.blank;
    assign status_code_o          = q.status;
    assign range_o                = q.range;
    assign display_count_o        = q.disp;
    assign display_sign_o         = q.disp_sign;

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    ramp_stop_a: assert property ((q.st == S_MEAS && conv_done_i) |=>
        !ramp_enable_cmd_o && !count_cmd_o ##1 !log_ramp_enable_o)
        else $error("ramp not withdrawn after conversion end");
    range_clear_a: assert property ($rose(clear_range_cmd_o) |->
        !under_range_status_o && !over_range_status_o && !display_blank_o)
        else $error("range decoder not cleared");
    under_seq_a: assert property (set_under_range_cmd_o |=> set_over_range_cmd_o &&
        under_range_lamp_o && under_range_status_o && over_range_status_o && display_blank_o)
        else $error("under-range sequence wrong");
    status_code_a: assert property (status_code_o ==
        {over_range_status_o, under_range_status_o})
        else $error("status code mismatch");
    range_down_a: assert property (range_down_cmd_o |->
        $past(range_o) > LRS_RANGE_MIN && range_o == $past(range_o) - 3'h1)
        else $error("range step down wrong");
    range_up_a: assert property (range_up_cmd_o |->
        $past(range_o) < LRS_RANGE_MAX && range_o == $past(range_o) + 3'h1)
        else $error("range step up wrong");
    zero_ref_a: assert property ((load_reference_cmd_o && $past(clear_count_cmd_o)) |->
        q.ref_cnt == '0 && !q.ref_sign)
        else $error("out-of-range reference not zero");
    rel_done_a: assert property ($fell(relative_zero_flag_o) |=>
        !relative_step_cmd_o ##1 display_transfer_cmd_o)
        else $error("relative conversion end not handled");

endmodule

`default_nettype wire

// [verif/lrs_conv_model.sv]
// converter model: answers each ramp with a done pulse and a result class
`timescale 1ns/1ps
`default_nettype none
module lrs_conv_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       ramp_i,
    input  wire logic [1:0] cls_i,
    input  wire logic [7:0] dly_i,
    output logic            done_o,
    output logic      [1:0] cls_o
);
    logic [7:0] cnt_q;
    logic       hit;

    assign hit = ramp_i && ((cnt_q + 8'h01) == dly_i);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q  <= 8'h00;
            done_o <= 1'b0;
            cls_o  <= 2'h0;
        end else begin
            cnt_q  <= ramp_i ? cnt_q + 8'h01 : 8'h00;
            done_o <= hit;
            // class means nothing between pulses: keep it moving so nothing leans on it
            cls_o  <= hit ? cls_i : ~cls_o;
        end
    end
endmodule
`default_nettype wire

// [verif/tb.sv]
// testbench: sequencer over APB against a behavioural range and relative model
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin num_errors++; \
    $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); end end
module tb;
    import lrs_pkg::*;
    localparam int          CW   = 14;
    localparam logic [31:0] AUTO = 32'h1;
    localparam logic [31:0] REF  = 32'h2;
    localparam logic [31:0] REL  = 32'h4;
    localparam logic [31:0] BTN  = 32'h8;
    logic          clk, rst, psel, penable, pwrite, pready, pslverr, done, ramp, xfer;
    logic          r_up, r_dn, clr, lref, ur_l, or_l, ur_s, or_s, blank, sign;
    logic [7:0]    paddr, p_dly;
    logic [31:0]   pwdata, prdata, rd;
    logic [1:0]    cls, p_cls, scode;
    logic [2:0]    range;
    logic [CW-1:0] preset, disp;
    logic          er;
    int            num_errors, num_checks, seed, m_range, ups, dns, clrs, lrefs, k;

    lrs_seq #(.CW(CW)) dut (.core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .preset_count_i(preset), .preset_sign_i(1'b0),
        .conv_done_i(done), .conv_class_i(cls), .ramp_enable_cmd_o(ramp), .log_ramp_enable_o(),
        .count_cmd_o(), .clear_range_cmd_o(), .set_under_range_cmd_o(), .set_over_range_cmd_o(),
        .range_down_cmd_o(r_dn), .range_up_cmd_o(r_up), .clear_count_cmd_o(clr),
        .load_reference_cmd_o(lref), .relative_step_cmd_o(), .display_transfer_cmd_o(xfer),
        .relative_zero_flag_o(), .under_range_lamp_o(ur_l), .over_range_lamp_o(or_l),
        .under_range_status_o(ur_s), .over_range_status_o(or_s), .display_blank_o(blank),
        .status_code_o(scode), .range_o(range), .display_count_o(disp), .display_sign_o(sign));
    lrs_conv_model conv (.clk_i(clk), .rst_i(rst), .ramp_i(ramp), .cls_i(p_cls), .dly_i(p_dly),
        .done_o(done), .cls_o(cls));

    always #5 clk = ~clk;

    task automatic end_of_test();
        if (num_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            num_errors++;
            end_of_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // counts command pulses up to and including the transfer
    task automatic wait_xfer();
        int n;
        n = 0;
        ups = 0;
        dns = 0;
        clrs = 0;
        lrefs = 0;
        do begin
            @(posedge clk);
            n++;
            ups += int'(r_up);
            dns += int'(r_dn);
            clrs += int'(clr);
            lrefs += int'(lref);
        end while (xfer !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            num_errors++;
            end_of_test();
        end
    endtask

    // park the sequencer so the new settings take effect from a clean start
    task automatic measure(input logic [31:0] ctrl, input logic [1:0] c, input logic [7:0] d);
        int n;
        apb(1'b1, LRS_CTRL_OFS, ctrl);
        n = 0;
        do begin
            apb(1'b0, LRS_STAT_OFS, 32'h0);
            n++;
        end while (rd[LRS_STAT_BUSY] !== 1'b0 && n < 200);
        `CHK("parked", 1'b0, rd[LRS_STAT_BUSY])
        p_cls <= c;
        p_dly <= d;
        apb(1'b1, LRS_CTRL_OFS, ctrl | (32'h1 << LRS_CTRL_RUN_BIT));
        wait_xfer();
    endtask

    task automatic expect_res(input logic au, input logic [1:0] c);
        int eu;
        int ed;
        eu = 0;
        ed = 0;
        while (au && c == CLS_OVER && m_range < 5) begin
            m_range++;
            eu++;
        end
        while (au && c == CLS_UNDER && m_range > 1) begin
            m_range--;
            ed++;
        end
        `CHK("range", m_range[2:0], range)
        `CHK("range_up", eu, ups)
        `CHK("range_down", ed, dns)
        `CHK("status_code", (c == CLS_IN) ? 2'b00 : (c == CLS_UNDER) ? 2'b11 : 2'b10, scode)
        `CHK("blank", c != CLS_IN, blank)
        `CHK("ur_lamp", c == CLS_UNDER, ur_l)
        `CHK("ur_status", c == CLS_UNDER, ur_s)
        `CHK("or_status", c != CLS_IN, or_s)
        `CHK("or_lamp", c == CLS_OVER, or_l)
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        num_errors = 0;
        num_checks = 0;
        seed = 99;
        m_range = 1;
        p_cls = CLS_IN;
        p_dly = 8'h0c;
        preset = CW'(5 + ({$random(seed)} % 30));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("range_rst", LRS_RANGE_RST, range)
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped_err", 1'b1, er)
        `CHK("unmapped_data", 32'h0, rd)
        apb(1'b1, LRS_STAT_OFS, 32'hff);
        `CHK("ro_err", 1'b1, er)
        measure(32'h0, CLS_UNDER, 8'h0c);
        expect_res(1'b0, CLS_UNDER);
        `CHK("dbm_clear", 0, clrs)
        measure(AUTO, CLS_OVER, 8'h0c);
        expect_res(1'b1, CLS_OVER);
        measure(AUTO, CLS_UNDER, 8'h09);
        expect_res(1'b1, CLS_UNDER);
        measure(32'h0, CLS_IN, 8'h0c);
        expect_res(1'b0, CLS_IN);
        `CHK("dbm_lref", 0, lrefs)
        measure(REF | BTN, CLS_OVER, 8'h0c);
        expect_res(1'b0, CLS_OVER);
        `CHK("ref_oor_disp", {CW{1'b0}}, disp)
        `CHK("ref_oor_clr", 1, clrs)
        `CHK("ref_oor_lref", 1, lrefs)
        apb(1'b0, LRS_REF_OFS, 32'h0);
        `CHK("ref_zero", 32'h0, rd)
        measure(REF | BTN, CLS_IN, 8'h0c);
        expect_res(1'b0, CLS_IN);
        `CHK("ref_disp", {CW{1'b0}}, disp)
        `CHK("ref_lref", 1, lrefs)
        measure(REF, CLS_IN, 8'h0c);
        `CHK("release_disp", {CW{1'b0}}, disp)
        for (int i = 0; i < 6; i++) begin
            k = $random(seed) % 8;
            p_dly <= 8'(12 + k);
            wait_xfer();
            `CHK("rel_count", CW'((k < 0) ? -k : k), disp)
            `CHK("rel_sign", k < 0, sign)
            `CHK("rel_lref", 0, lrefs)
        end
        apb(1'b0, LRS_STAT_OFS, 32'h0);
        `CHK("auto_rel", MODE_REL, rd[10:9])
        measure(REL, CLS_UNDER, 8'h0c);
        expect_res(1'b0, CLS_UNDER);
        `CHK("rel_oor_disp", {CW{1'b0}}, disp)
        `CHK("rel_oor_clr", 1, clrs)
        end_of_test();
    end
endmodule
`default_nettype wire
